// ===== shared/drc_consts.vh
// constants for the dram refresh and access controller
`ifndef DRC_CONSTS_VH
`define DRC_CONSTS_VH
`define DRC_REF_ROW_RST 9'h1ff
`define DRC_DIV_61 7'h3d
`define DRC_DIV_91 7'h5b
`define DRC_DIV_106 7'h6a
`define DRC_DIV_121 7'h79
`define DRC_REF_LEN_3 3'h3
`define DRC_REF_LEN_4 3'h4
`define DRC_WAIT_CYCLES 2'h1
`endif

// ===== hdl/drc_controller.v
// dram refresh and access controller: latches, refresh timer, arbiter, strobes
//
// Notes on behaviour
// [R1] wait strap high adds one wait state
// [R2] reset sets row ones, clears requests, divider
// [R3] straps 000/001 select external refresh, timer held; the divider is held for 000 only and counts unused for 001
// [R4] timer divides by 61, 91, 106, 121
// [R5] refresh lasts three or four clocks by code
// [R6] timer restarts on request, cleared when straps low
// [R7] system holds straps low or reset four clocks
// [R8] row latch transparent while latch strobe high
// [R9] refresh row decrements after each refresh
// [R10] wait strap rising edge loads row ones
// [R11] nine address lines carry row, column, refresh
// [R12] arbiter runs inhibited cycle afterwards
// [R13] control drives strobes, ready, mux, timer reset
// [R14] bank selects decode to one row strobe
// [R15] upper bank change also drops other column strobe
// [R16] arbitration happens on the falling clock edge
// [R17] latch before access with refresh pending: refresh
// [R18] ready low on wait strap or refresh
// [R19] access strobe high ends access, back to idle
// [R20] external refresh request synchronized, then pending
`timescale 1ns/1ps
`include "drc_consts.vh"
module drc_controller #(
    parameter ADDR_W = 9
) (
    input wire sys_clk,
    input wire rst_n,
    input wire wait_timing_strap,
    input wire freq_select_strap_0,
    input wire freq_select_strap_1,
    input wire addr_latch_strobe,
    input wire access_strobe_n,
    input wire bank_select_hi,
    input wire bank_select_lo,
    input wire refresh_request_n,
    input wire [ADDR_W-1:0] row_addr_in,
    input wire [ADDR_W-1:0] col_addr_in,
    output wire [ADDR_W-1:0] memory_addr_out,
    output reg [3:0] row_strobe_outputs_n,
    output reg [1:0] column_strobe_outputs_n,
    output reg ready
);
    // fsm state codes
    localparam ST_IDLE = 2'h0;
    localparam ST_ACC = 2'h1;
    localparam ST_REF = 2'h2;

    // strap synchronisers, two flops each
    reg [2:0] strap_s1_q;
    reg [2:0] strap_q;
    // access-side synchronisers
    reg [3:0] ctl_s1_q;
    reg [3:0] ctl_q;
    // external refresh request synchroniser
    reg ref_s1_q;
    reg ref_s2_q;
    // previous wait strap for edge detection
    reg wait_prev_q;
    // latched row and column addresses
    reg [ADDR_W-1:0] row_q;
    reg [ADDR_W-1:0] col_q;
    // refresh row counter
    reg [ADDR_W-1:0] ref_row_q;
    // rate divider count and pending refresh
    reg [6:0] div_q;
    reg pend_q;
    // cycle state and counters
    reg [1:0] state_q;
    reg [2:0] cnt_q;
    reg [1:0] bank_q;
    reg bank_hi_at_latch_q;
    reg both_cas_q;
    reg [1:0] mux_sel_q;
    reg latch_prev_q;
    reg acc_seen_q;
    reg ready_nf_q;

    wire [2:0] code = strap_q;
    wire w_ale = ctl_q[0];
    wire w_acx_n = ctl_q[1];
    wire w_bhi = ctl_q[2];
    wire w_blo = ctl_q[3];
    wire ext_mode = (code == 3'h0) || (code == 3'h1); // [R3]
    wire straps_low = (code == 3'h0);

    // divide ratio per strap code
    function [6:0] div_of;
        input [2:0] c;
        begin
            case (c)
                3'h2, 3'h4: div_of = `DRC_DIV_61; // [R4]
                3'h3, 3'h5: div_of = `DRC_DIV_91; // [R4]
                3'h6: div_of = `DRC_DIV_106; // [R4]
                3'h7: div_of = `DRC_DIV_121; // [R4]
                default: div_of = `DRC_DIV_61;
            endcase
        end
    endfunction

    // refresh cycle length per strap code
    function [2:0] ref_len;
        input [2:0] c;
        begin
            if (c == 3'h1 || c == 3'h2 || c == 3'h4) begin
                ref_len = `DRC_REF_LEN_3; // [R5]
            end else begin
                ref_len = `DRC_REF_LEN_4; // [R5]
            end
        end
    endfunction

    wire div_hit = !ext_mode && (div_q == div_of(code) - 7'h1);
    wire new_req = ext_mode ? !ref_s2_q : div_hit; // [R20]
    wire latch_rise = w_ale && !latch_prev_q;

    // row latch is transparent while the latch strobe is high; bypasses the
    // flops for speed, so the strobe itself is treated as a local control
    wire [ADDR_W-1:0] row_view = addr_latch_strobe ? row_addr_in : row_q; // [R8]
    assign memory_addr_out = (mux_sel_q == 2'h2) ? ref_row_q :
                             (mux_sel_q == 2'h1) ? col_q : row_view; // [R11]

    // input synchronisers; first stage read only by second
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_q <= 3'h0;
            strap_q <= 3'h0;
            ctl_s1_q <= 4'h2;
            ctl_q <= 4'h2;
            ref_s1_q <= 1'b1; // [R2]
            ref_s2_q <= 1'b1; // [R2]
        end else begin
            strap_s1_q <= {wait_timing_strap, freq_select_strap_1, freq_select_strap_0};
            strap_q <= strap_s1_q;
            ctl_s1_q <= {bank_select_lo, bank_select_hi, access_strobe_n, addr_latch_strobe};
            ctl_q <= ctl_s1_q;
            ref_s1_q <= refresh_request_n;
            ref_s2_q <= ref_s1_q;
        end
    end

    // row register holds value once latch strobe falls
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            row_q <= {ADDR_W{1'b0}};
            col_q <= {ADDR_W{1'b0}};
        end else begin
            if (addr_latch_strobe) begin
                row_q <= row_addr_in; // [R8]
            end
            col_q <= col_addr_in;
        end
    end

    // refresh timer and pending flag; new request wins over service clear
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 7'h0; // [R2]
            pend_q <= 1'b0; // [R2]
        end else begin
            if (straps_low || div_hit || state_q == ST_REF) begin
                div_q <= 7'h0; // [R6] [R13]
            end else begin
                div_q <= div_q + 7'h1; // [R4]
            end
            if (new_req) begin
                pend_q <= 1'b1;
            end else if (state_q == ST_REF && cnt_q == 3'h0) begin
                pend_q <= 1'b0;
            end
        end
    end

    // refresh row counter with strap edge preset
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_row_q <= `DRC_REF_ROW_RST; // [R2]
            wait_prev_q <= 1'b0;
        end else begin
            wait_prev_q <= code[2];
            if (code[2] && !wait_prev_q) begin
                ref_row_q <= `DRC_REF_ROW_RST; // [R10]
            end else if (state_q == ST_REF && cnt_q == 3'h1) begin
                ref_row_q <= ref_row_q - 9'h1; // [R9]
            end
        end
    end

    // arbitration on falling edge picks refresh or access
    always @(negedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            bank_q <= 2'h0;
            bank_hi_at_latch_q <= 1'b0;
            both_cas_q <= 1'b0;
            mux_sel_q <= 2'h0;
            latch_prev_q <= 1'b0;
            acc_seen_q <= 1'b0;
        end else begin
            latch_prev_q <= w_ale;
            // select latch follows the bank pins while the latch strobe is high
            if (w_ale) begin
                bank_q <= {w_bhi, w_blo}; // [R14]
            end
            // a new latch cycle rearms the detector; any later upper bank change
            // up to the end of the access drops both column strobes
            if (latch_rise) begin
                bank_hi_at_latch_q <= w_bhi;
                both_cas_q <= 1'b0;
            end else if (w_bhi != bank_hi_at_latch_q) begin
                both_cas_q <= 1'b1; // [R15]
            end
            case (state_q)
                ST_IDLE: begin
                    mux_sel_q <= 2'h0;
                    if (pend_q && (w_acx_n || latch_rise)) begin
                        state_q <= ST_REF; // [R16] [R17] [R12]
                        cnt_q <= ref_len(code) - 3'h1; // [R5]
                        mux_sel_q <= 2'h2;
                    end else if (!w_acx_n) begin
                        state_q <= ST_ACC; // [R16]
                        cnt_q <= {2'h0, code[2]}; // [R1]
                        acc_seen_q <= 1'b0;
                    end
                end
                ST_ACC: begin
                    mux_sel_q <= 2'h1;
                    if (cnt_q != 3'h0) begin
                        cnt_q <= cnt_q - 3'h1; // [R1]
                    end
                    acc_seen_q <= 1'b1;
                    if (w_acx_n) begin
                        state_q <= ST_IDLE; // [R19]
                        both_cas_q <= 1'b0;
                        mux_sel_q <= 2'h0;
                    end
                end
                ST_REF: begin
                    if (cnt_q == 3'h0) begin
                        state_q <= ST_IDLE; // [R12]
                        mux_sel_q <= 2'h0;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ready low for wait state or refresh, released on rising edge
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_nf_q <= 1'b1;
        end else if (state_q == ST_REF || (state_q == ST_ACC && cnt_q != 3'h0)) begin
            ready_nf_q <= 1'b0; // [R18]
        end else if (state_q == ST_IDLE && w_ale && code[2]) begin
            ready_nf_q <= 1'b0; // [R18]
        end else begin
            ready_nf_q <= 1'b1;
        end
    end

    // strobes decoded from the cycle state
    always @* begin
        ready = ready_nf_q; // [R13]
        row_strobe_outputs_n = 4'hf;
        column_strobe_outputs_n = 2'h3;
        if (state_q == ST_REF) begin
            row_strobe_outputs_n = 4'h0; // [R13]
        end else if (state_q == ST_ACC) begin
            row_strobe_outputs_n = ~(4'h1 << bank_q); // [R14]
            if (acc_seen_q) begin
                column_strobe_outputs_n = ~(2'h1 << bank_q[1]);
                if (both_cas_q) begin
                    column_strobe_outputs_n = 2'h0; // [R15]
                end
            end
        end
    end
endmodule // drc_controller

// ===== bench/drc_controller_properties.sv
// port checker for the dram refresh and access controller
`timescale 1ns/1ps
`include "drc_consts.vh"
module drc_controller_props #(
    parameter ADDR_W = 9
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wait_timing_strap,
    input wire logic freq_select_strap_0,
    input wire logic freq_select_strap_1,
    input wire logic addr_latch_strobe,
    input wire logic access_strobe_n,
    input wire logic bank_select_hi,
    input wire logic bank_select_lo,
    input wire logic refresh_request_n,
    input wire logic [ADDR_W-1:0] row_addr_in,
    input wire logic [ADDR_W-1:0] col_addr_in,
    input wire logic [ADDR_W-1:0] memory_addr_out,
    input wire logic [3:0] row_strobe_outputs_n,
    input wire logic [1:0] column_strobe_outputs_n,
    input wire logic ready
);
wire [2:0] code = {wait_timing_strap, freq_select_strap_1, freq_select_strap_0};
wire ref_on = (row_strobe_outputs_n == 4'h0); // all banks strobed at once: refresh
wire ext_mode = (code[2:1] == 2'h0); // external refresh codes
wire [2:0] len_exp = $onehot(code) ? `DRC_REF_LEN_3 : `DRC_REF_LEN_4;
reg [2:0] len_q; // clocks spent in the current refresh
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) len_q <= 3'h0;
    else len_q <= ref_on ? len_q + 3'h1 : 3'h0;
end
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
property p_one_row;
    !(&column_strobe_outputs_n) |-> $countones(~row_strobe_outputs_n) == 1;
endproperty
a_one_row: assert property (p_one_row) else $error("column strobe without one row");
property p_decode;
    column_strobe_outputs_n == 2'h1 || column_strobe_outputs_n == 2'h2
        |-> row_strobe_outputs_n == ~(4'h1 << {bank_select_hi, bank_select_lo});
endproperty
a_decode: assert property (p_decode) else $error("wrong row strobe for bank");
property p_transp;
    addr_latch_strobe && ext_mode && refresh_request_n && &row_strobe_outputs_n
        |-> memory_addr_out == row_addr_in;
endproperty
a_transp: assert property (p_transp) else $error("row latch not transparent");
property p_end;
    $rose(access_strobe_n) |-> ##[1:5] &column_strobe_outputs_n;
endproperty
a_end: assert property (p_end) else $error("column strobes held after access");
property p_rdy;
    $fell(addr_latch_strobe) && wait_timing_strap |-> ##[0:4] !ready;
endproperty
a_rdy: assert property (p_rdy) else $error("no wait state with strap high");
property p_held;
    (code == 3'h0 && refresh_request_n) [*8] |-> !ref_on;
endproperty
a_held: assert property (p_held) else $error("refresh with timer held");
property p_ext;
    $fell(refresh_request_n) && ext_mode && access_strobe_n && !ref_on |-> ##[1:6] ref_on;
endproperty
a_ext: assert property (p_ext) else $error("external request not served");
property p_len;
    $fell(ref_on) |-> len_q == len_exp;
endproperty
a_len: assert property (p_len) else $error("refresh length wrong");
c_ref: cover property ($rose(ref_on));
c_both: cover property (column_strobe_outputs_n == 2'h0);
c_wait: cover property ($fell(ready));
endmodule // drc_controller_props
bind drc_controller drc_controller_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk, .rst_n,
    .wait_timing_strap, .freq_select_strap_0, .freq_select_strap_1, .addr_latch_strobe,
    .access_strobe_n, .bank_select_hi, .bank_select_lo, .refresh_request_n, .row_addr_in,
    .col_addr_in, .memory_addr_out, .row_strobe_outputs_n, .column_strobe_outputs_n, .ready);

// ===== bench/drc_dram_model.sv
// dram array model: records each refresh row, length and spacing
`timescale 1ns/1ps
module drc_dram_model (
    input wire logic sys_clk,
    input wire logic [3:0] row_strobe_outputs_n,
    input wire logic [8:0] memory_addr_out,
    output logic [15:0] ref_cnt = 16'h0,
    output logic [15:0] ref_gap = 16'h0,
    output logic [8:0] ref_row = 9'h0,
    output logic [7:0] ref_len = 8'h0
);
logic on_q = 1'b0;
logic [15:0] t_q = 16'h0; // clocks since last refresh start
logic [7:0] run_q = 8'h0;
// a refresh strobes every bank with no column strobe
always @(posedge sys_clk) begin
    on_q <= (row_strobe_outputs_n == 4'h0);
    t_q <= t_q + 16'h1;
    run_q <= (row_strobe_outputs_n == 4'h0) ? run_q + 8'h1 : 8'h0;
    if (row_strobe_outputs_n == 4'h0 && !on_q) begin
        ref_cnt <= ref_cnt + 16'h1;
        ref_row <= memory_addr_out;
        ref_gap <= t_q;
        t_q <= 16'h1;
    end
    if (row_strobe_outputs_n != 4'h0 && on_q) ref_len <= run_q;
end
endmodule // drc_dram_model

// ===== bench/dram_refresh_access_controller_bench.sv
// self-checking bench for the dram refresh and access controller
`timescale 1ns/1ps
`include "drc_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module dram_refresh_access_controller_bench;
integer miscompares = 0;
integer checked = 0;
integer i;
reg sys_clk = 1'b0;
reg rst_n = 1'b0;
reg [2:0] code = 3'h0; // wait, fs1, fs0 straps
reg ale = 1'b0;
reg acc_n = 1'b1;
reg [1:0] bank = 2'h0;
reg req_n = 1'b1;
reg [8:0] ra = 9'h0;
reg [8:0] ca = 9'h0;
wire [8:0] ma;
wire [3:0] rs_n;
wire [1:0] cs_n;
wire rdy;
wire [15:0] ref_cnt;
wire [15:0] ref_gap;
wire [8:0] ref_row;
wire [7:0] ref_len;
always #20 sys_clk = ~sys_clk; // 25 MHz
drc_controller #(.ADDR_W(9)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .wait_timing_strap(code[2]), .freq_select_strap_1(code[1]), .freq_select_strap_0(code[0]),
    .addr_latch_strobe(ale), .access_strobe_n(acc_n), .bank_select_hi(bank[1]),
    .bank_select_lo(bank[0]), .refresh_request_n(req_n), .row_addr_in(ra), .col_addr_in(ca),
    .memory_addr_out(ma), .row_strobe_outputs_n(rs_n), .column_strobe_outputs_n(cs_n),
    .ready(rdy));
drc_dram_model u_dram (.sys_clk(sys_clk), .row_strobe_outputs_n(rs_n), .memory_addr_out(ma),
    .ref_cnt(ref_cnt), .ref_gap(ref_gap), .ref_row(ref_row), .ref_len(ref_len));
// straps pass a two-flop synchronizer, so give them time to land
task strap(input [2:0] c);
    begin
        @(negedge sys_clk) code = c;
        repeat (6) @(negedge sys_clk);
    end
endtask
// one access; w: 0 ready stays high, 1 ready drops, 2 not judged
task access(input [1:0] b, input [8:0] r, input [8:0] c, input [1:0] w, input flip);
    integer n;
    reg low;
    begin
        low = 1'b0;
        @(negedge sys_clk) begin ale = 1'b1; bank = b; ra = r; ca = c; end
        @(negedge sys_clk) ale = 1'b0;
        if (w == 2'h0 && &rs_n) `CHK(ma, r)
        @(negedge sys_clk) begin acc_n = 1'b0; bank[1] = b[1] ^ flip; end
        for (n = 0; n < 40 && &cs_n; n = n + 1) @(negedge sys_clk) low = low | !rdy;
        repeat (3) @(negedge sys_clk) low = low | !rdy;
        `CHK(rs_n, ~(4'h1 << b))
        `CHK(cs_n == 2'h0, flip)
        `CHK(ma, c)
        if (!w[1]) `CHK(low, w[0])
        acc_n = 1'b1;
        bank = b;
        repeat (6) @(negedge sys_clk);
        `CHK(cs_n, 2'h3)
    end
endtask
// single-clock request pulse, then the served row and length
task ext_ref(input [7:0] len, input [8:0] r);
    integer n;
    reg [15:0] k;
    begin
        k = ref_cnt;
        @(negedge sys_clk) req_n = 1'b0;
        @(negedge sys_clk) req_n = 1'b1;
        for (n = 0; n < 20 && ref_cnt == k; n = n + 1) @(negedge sys_clk);
        `CHK(ref_row, r)
        repeat (6) @(negedge sys_clk);
        `CHK(ref_len, len)
    end
endtask
// timer mode: first refresh after hold, then spacing to the next
task int_ref(input [2:0] c, input [7:0] div, input [7:0] len);
    integer n;
    reg [15:0] k;
    reg [8:0] r;
    begin
        strap(3'h0);
        strap(c);
        k = ref_cnt;
        for (n = 0; n < 300 && ref_cnt == k; n = n + 1) @(negedge sys_clk);
        r = ref_row;
        if (c[2]) `CHK(r, 9'h1ff)
        for (n = 0; n < 300 && ref_cnt == k + 16'h1; n = n + 1) @(negedge sys_clk);
        `CHK(ref_row, r - 9'h1)
        `CHK(ref_gap >= div && ref_gap <= div + len + 8'h3, 1'b1)
        repeat (6) @(negedge sys_clk);
        `CHK(ref_len, len)
    end
endtask
task conclude;
    begin
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end
endtask
initial begin
    #2000000;
    miscompares++;
    conclude;
end
// straps low and reset held eight clocks
initial begin
    repeat (8) @(negedge sys_clk);
    `CHK({rdy, rs_n, cs_n}, 7'h7f)
    rst_n = 1'b1;
    strap(3'h1);
    ext_ref(8'h3, 9'h1ff);
    access(2'h0, 9'h155, 9'h0aa, 2'h0, 1'b0);
    access(2'h3, 9'h0aa, 9'h155, 2'h0, 1'b1);
    access(2'h1, 9'h0f0, 9'h10f, 2'h0, 1'b0);
    @(negedge sys_clk) req_n = 1'b0;
    @(negedge sys_clk) req_n = 1'b1;
    access(2'h2, 9'h03c, 9'h1c3, 2'h2, 1'b0);
    strap(3'h0);
    ext_ref(8'h4, 9'h1fd);
    for (i = 2; i < 8; i = i + 1)
        int_ref(i[2:0], i[1] & i[2] ? (i[0] ? `DRC_DIV_121 : `DRC_DIV_106) :
            (i[0] ? `DRC_DIV_91 : `DRC_DIV_61), (i == 2 || i == 4) ? 8'h3 : 8'h4);
    access(2'h2, 9'h111, 9'h0ee, 2'h1, 1'b0);
    conclude;
end
endmodule // dram_refresh_access_controller_bench
